// ==== hdl/cmp_reg_bank.v ====
// Operation
// - Left record mutes, seven bits, reset ones
// - Right record mutes, low seven, reset ones
// - Voice gain code five bits, reset 08h
// - Three voice feed mutes, default E800h
// - Speaker volume input two-bit selectors
// - Class AB/D select, AB right source
// - Mono selector and headphone input selects
// - Mic boost fields two bits each
// - Bias threshold 600, 1200, 1800 uA
// - Seven power-down requests, default EF00h
// - Power-down requests gate listed units
// - Ready status; DAC/ADC ready inverse requests
// - Port role bit: zero master, one slave
// - Separate ADC frame clock when rates differ
// - Bit clock polarity inverts when set
// - Sigma-delta clock source and divider
// - Mode bit: PCM A/B or frame invert; main port frame invert only without separate ADC frame clock
// - Sample length 16, 20, 24, 32
// - Format I2S, right, left, PCM
// - Voice enable takes over four pins
// - Voice ADC enable routes right ADC
// - Voice power gates voice clock, filters
// - Odd address reads return zero
// - Write to address zero restores defaults
`timescale 1ns/1ps
`include "cmp_regs.vh"

module cmp_reg_bank (
	// Clock and reset
	input  wire        clk_in,
	input  wire        rst_n_in,
	// Register access port
	input  wire [7:0]  reg_addr_in,
	input  wire [15:0] reg_wdata_in,
	input  wire        reg_wr_in,
	input  wire        reg_rd_in,
	output wire [15:0] reg_rdata_out,
	output wire        reg_rvalid_out,
	// Analog readiness
	input  wire        vref_ready_in,
	input  wire        mixer_ready_in,
	// Record mixer and voice routing
	output wire [6:0]  rec_left_mute_out,
	output wire [6:0]  rec_right_mute_out,
	output wire [4:0]  voice_gain_code_out,
	output wire        voice_hp_mute_out,
	output wire        voice_spk_mute_out,
	output wire        voice_mono_mute_out,
	// Output mixer selection
	output wire [1:0]  speaker_left_gain_stage_sel_out,
	output wire [1:0]  speaker_right_gain_stage_sel_out,
	output wire        amp_class_select_out,
	output wire        amp_right_from_left_out,
	output wire        hp_left_from_mixer_out,
	output wire        hp_right_from_mixer_out,
	output wire [1:0]  mono_in_sel_out,
	// Microphone control
	output wire [1:0]  first_mic_preamp_gain_out,
	output wire [1:0]  second_mic_preamp_gain_out,
	output wire        first_mic_supply_low_out,
	output wire        second_mic_supply_low_out,
	output wire [1:0]  bias_threshold_level_out,
	// Unit power-down gates
	output wire        adc_pd_out,
	output wire        dac_pd_out,
	output wire        mixer_pd_out,
	output wire        vref_pd_out,
	output wire        int_clk_pd_out,
	output wire        hp_out_pd_out,
	output wire        mono_out_pd_out,
	output wire        spk_out_pd_out,
	// Main serial port
	output wire        main_slave_out,
	output wire        main_sep_adc_fs_out,
	output wire        main_bclk_inv_out,
	output wire        main_sd_from_div_out,
	output wire [2:0]  main_sd_div_log2_out,
	output wire        main_sd_div_valid_out,
	output wire        main_lin_filter_out,
	output wire        main_pcm_mode_b_out,
	output wire        main_frame_inv_out,
	output wire [1:0]  main_len_code_out,
	output wire [1:0]  main_fmt_code_out,
	// Voice serial port
	output wire        voice_port_pin_takeover_out,
	output wire        voice_slave_out,
	output wire        voice_adc_en_out,
	output wire        voice_bclk_inv_out,
	output wire        voice_pcm_mode_b_out,
	output wire        voice_frame_inv_out,
	output wire [1:0]  voice_len_code_out,
	output wire [1:0]  voice_fmt_code_out,
	// Power enables and clock gates
	output wire [15:0] pwr_en_one_out,
	output wire [15:0] pwr_en_two_out,
	output wire        voice_clk_en_out,
	output wire        voice_port_active_out,
	output wire        dac_l_clk_en_out,
	output wire        dac_r_clk_en_out,
	output wire        adc_l_clk_en_out,
	output wire        adc_r_clk_en_out
);

	reg  [15:0] rec_mutes_r;
	reg  [15:0] voice_vol_r;
	reg  [15:0] out_mix_r;
	reg  [15:0] rsvd_word_r;
	reg  [15:0] mic_ctrl_r;
	reg  [15:0] pwr_down_r;
	reg  [15:0] main_port_r;
	reg  [15:0] voice_port_r;
	reg  [15:0] pwr_en_one_r;
	reg  [15:0] pwr_en_two_r;
	reg  [15:0] rdata_r;
	reg  [15:0] rdata_nxt;
	reg         rvalid_r;
	wire [3:0]  pd_status;

	// Masked merge of a write into a stored word
	function [15:0] merge;
		input [15:0] old_val;
		input [15:0] new_val;
		input [15:0] mask;
		begin
			merge = (old_val & ~mask) | (new_val & mask);
		end
	endfunction

	// Frame inversion applies only outside PCM format
	function frame_inv;
		input       mode_bit;
		input [1:0] fmt;
		begin
			frame_inv = mode_bit & (fmt != `CMP_FMT_PCM);
		end
	endfunction

	// threshold level decode
	// 0: 600uA, 1: 1200uA, 2: 1800uA
	function [1:0] thr_level;
		input [1:0] code;
		begin
			thr_level = code[1] ? 2'h2 : {1'b0, code[0]};
		end
	endfunction

	wire write_hit = reg_wr_in;

	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rec_mutes_r  <= `CMP_RST_REC_MUTES;
			voice_vol_r  <= `CMP_RST_VOICE_VOL;
			out_mix_r    <= `CMP_RST_OUT_MIX;
			rsvd_word_r  <= `CMP_RST_RSVD_WORD;
			mic_ctrl_r   <= `CMP_RST_MIC_CTRL;
			pwr_down_r   <= `CMP_RST_PWR_DOWN;
			main_port_r  <= `CMP_RST_MAIN_PORT;
			voice_port_r <= `CMP_RST_VOICE_PORT;
			pwr_en_one_r <= `CMP_RST_PWR_EN_ONE;
			pwr_en_two_r <= `CMP_RST_PWR_EN_TWO;
		end else if (write_hit) begin
			case (reg_addr_in)
				`CMP_ADDR_SOFT_RESET: begin
					rec_mutes_r  <= `CMP_RST_REC_MUTES;
					voice_vol_r  <= `CMP_RST_VOICE_VOL;
					out_mix_r    <= `CMP_RST_OUT_MIX;
					rsvd_word_r  <= `CMP_RST_RSVD_WORD;
					mic_ctrl_r   <= `CMP_RST_MIC_CTRL;
					pwr_down_r   <= `CMP_RST_PWR_DOWN;
					main_port_r  <= `CMP_RST_MAIN_PORT;
					voice_port_r <= `CMP_RST_VOICE_PORT;
					pwr_en_one_r <= `CMP_RST_PWR_EN_ONE;
					pwr_en_two_r <= `CMP_RST_PWR_EN_TWO;
				end
				`CMP_ADDR_REC_MUTES: begin
					rec_mutes_r <= merge(rec_mutes_r, reg_wdata_in, `CMP_WM_REC_MUTES);
				end
				`CMP_ADDR_VOICE_VOL: begin
					voice_vol_r <= merge(voice_vol_r, reg_wdata_in, `CMP_WM_VOICE_VOL);
				end
				`CMP_ADDR_OUT_MIX: begin
					out_mix_r <= merge(out_mix_r, reg_wdata_in, `CMP_WM_OUT_MIX);
				end
				`CMP_ADDR_RSVD_WORD: begin
					rsvd_word_r <= merge(rsvd_word_r, reg_wdata_in, `CMP_WM_RSVD_WORD);
				end
				`CMP_ADDR_MIC_CTRL: begin
					mic_ctrl_r <= merge(mic_ctrl_r, reg_wdata_in, `CMP_WM_MIC_CTRL);
				end
				`CMP_ADDR_PWR_DOWN: begin
					pwr_down_r <= merge(pwr_down_r, reg_wdata_in, `CMP_WM_PWR_DOWN);
				end
				`CMP_ADDR_MAIN_PORT: begin
					main_port_r <= merge(main_port_r, reg_wdata_in, `CMP_WM_MAIN_PORT);
				end
				`CMP_ADDR_VOICE_PORT: begin
					voice_port_r <= merge(voice_port_r, reg_wdata_in, `CMP_WM_VOICE_PORT);
				end
				`CMP_ADDR_PWR_EN_ONE: begin
					pwr_en_one_r <= merge(pwr_en_one_r, reg_wdata_in, `CMP_WM_PWR_EN_ONE);
				end
				`CMP_ADDR_PWR_EN_TWO: begin
					pwr_en_two_r <= merge(pwr_en_two_r, reg_wdata_in, `CMP_WM_PWR_EN_TWO);
				end
				default: begin
					rec_mutes_r <= rec_mutes_r;
				end
			endcase
		end
	end

	assign pd_status = {vref_ready_in, mixer_ready_in,
	                    ~pwr_down_r[`CMP_PD_DAC], ~pwr_down_r[`CMP_PD_ADC]};

	always @* begin
		rdata_nxt = 16'h0000;
		if (!reg_addr_in[0]) begin
			case (reg_addr_in)
				`CMP_ADDR_REC_MUTES:  rdata_nxt = rec_mutes_r & `CMP_WM_REC_MUTES;
				`CMP_ADDR_VOICE_VOL:  rdata_nxt = voice_vol_r & `CMP_WM_VOICE_VOL;
				`CMP_ADDR_OUT_MIX:    rdata_nxt = out_mix_r & `CMP_WM_OUT_MIX;
				`CMP_ADDR_RSVD_WORD:  rdata_nxt = rsvd_word_r;
				`CMP_ADDR_MIC_CTRL:   rdata_nxt = mic_ctrl_r & `CMP_WM_MIC_CTRL;
				`CMP_ADDR_PWR_DOWN:   rdata_nxt = (pwr_down_r & `CMP_WM_PWR_DOWN) | {12'h000, pd_status};
				`CMP_ADDR_MAIN_PORT:  rdata_nxt = main_port_r & `CMP_WM_MAIN_PORT;
				`CMP_ADDR_VOICE_PORT: rdata_nxt = voice_port_r & `CMP_WM_VOICE_PORT;
				`CMP_ADDR_PWR_EN_ONE: rdata_nxt = pwr_en_one_r;
				`CMP_ADDR_PWR_EN_TWO: rdata_nxt = pwr_en_two_r;
				default:              rdata_nxt = 16'h0000;
			endcase
		end
	end

	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rdata_r  <= 16'h0000;
			rvalid_r <= 1'b0;
		end else begin
			rvalid_r <= reg_rd_in;
			if (reg_rd_in) begin
				rdata_r <= rdata_nxt;
			end
		end
	end

	assign reg_rdata_out  = rdata_r;
	assign reg_rvalid_out = rvalid_r;

	assign rec_left_mute_out  = rec_mutes_r[`CMP_REC_L_MSB:`CMP_REC_L_LSB];
	assign rec_right_mute_out = rec_mutes_r[`CMP_REC_R_MSB:`CMP_REC_R_LSB];
	assign voice_gain_code_out = voice_vol_r[`CMP_VOICE_GAIN_MSB:`CMP_VOICE_GAIN_LSB];
	assign voice_hp_mute_out   = voice_vol_r[`CMP_VOICE_HP_MUTE];
	assign voice_spk_mute_out  = voice_vol_r[`CMP_VOICE_SPK_MUTE];
	assign voice_mono_mute_out = voice_vol_r[`CMP_VOICE_MONO_MUTE];

	assign speaker_left_gain_stage_sel_out  = out_mix_r[`CMP_SPK_L_SEL_MSB:`CMP_SPK_L_SEL_LSB];
	assign speaker_right_gain_stage_sel_out = out_mix_r[`CMP_SPK_R_SEL_MSB:`CMP_SPK_R_SEL_LSB];
	assign amp_class_select_out    = out_mix_r[`CMP_AMP_CLASS_D];
	assign amp_right_from_left_out = ~out_mix_r[`CMP_AMP_CLASS_D] & out_mix_r[`CMP_AB_R_FROM_L];
	assign hp_left_from_mixer_out  = out_mix_r[`CMP_HP_L_SEL];
	assign hp_right_from_mixer_out = out_mix_r[`CMP_HP_R_SEL];
	assign mono_in_sel_out         = out_mix_r[`CMP_MONO_SEL_MSB:`CMP_MONO_SEL_LSB];

	assign first_mic_preamp_gain_out  = mic_ctrl_r[`CMP_MIC1_BOOST_MSB:`CMP_MIC1_BOOST_LSB];
	assign second_mic_preamp_gain_out = mic_ctrl_r[`CMP_MIC2_BOOST_MSB:`CMP_MIC2_BOOST_LSB];
	assign first_mic_supply_low_out   = mic_ctrl_r[`CMP_MIC1_BIAS_V];
	assign second_mic_supply_low_out  = mic_ctrl_r[`CMP_MIC2_BIAS_V];
	assign bias_threshold_level_out = thr_level(mic_ctrl_r[`CMP_BIAS_THR_MSB:`CMP_BIAS_THR_LSB]);

	wire analog_core_off_req   = pwr_down_r[`CMP_PD_ANALOG_CORE];
	wire internal_clock_off_req = pwr_down_r[`CMP_PD_INT_CLK];
	wire mixer_off_req         = pwr_down_r[`CMP_PD_MIXER];
	wire line_outputs_off_req  = pwr_down_r[`CMP_PD_LINE_OUT];
	wire dac_off_req           = pwr_down_r[`CMP_PD_DAC];
	wire adc_off_req           = pwr_down_r[`CMP_PD_ADC];
	assign adc_pd_out      = adc_off_req | analog_core_off_req | internal_clock_off_req;
	assign dac_pd_out      = dac_off_req | analog_core_off_req | internal_clock_off_req;
	assign mixer_pd_out    = mixer_off_req | analog_core_off_req;
	assign vref_pd_out     = analog_core_off_req;
	assign int_clk_pd_out  = internal_clock_off_req;
	assign hp_out_pd_out   = mixer_off_req | analog_core_off_req | line_outputs_off_req;
	assign mono_out_pd_out = line_outputs_off_req;
	assign spk_out_pd_out  = pwr_down_r[`CMP_PD_SPK];

	assign main_slave_out       = main_port_r[`CMP_MAIN_SLAVE];
	assign main_sep_adc_fs_out  = main_port_r[`CMP_MAIN_SEP_ADC_FS];
	assign main_bclk_inv_out    = main_port_r[`CMP_MAIN_BCLK_INV];
	assign main_sd_from_div_out  = main_port_r[`CMP_MAIN_SD_FROM_DIV];
	assign main_sd_div_log2_out  = main_port_r[`CMP_MAIN_SD_DIV_MSB:`CMP_MAIN_SD_DIV_LSB] + 3'h1;
	assign main_sd_div_valid_out = main_port_r[`CMP_MAIN_SD_DIV_MSB:`CMP_MAIN_SD_DIV_LSB] <= `CMP_SD_DIV_MAX;
	assign main_lin_filter_out   = main_port_r[`CMP_MAIN_LIN_FILT];
	assign main_pcm_mode_b_out = main_port_r[`CMP_PORT_MODE_BIT] &
	                             (main_port_r[`CMP_PORT_FMT_MSB:`CMP_PORT_FMT_LSB] == `CMP_FMT_PCM);
	assign main_frame_inv_out  = frame_inv(main_port_r[`CMP_PORT_MODE_BIT],
	                                       main_port_r[`CMP_PORT_FMT_MSB:`CMP_PORT_FMT_LSB]) &
	                             ~main_port_r[`CMP_MAIN_SEP_ADC_FS];
	assign main_len_code_out = main_port_r[`CMP_PORT_LEN_MSB:`CMP_PORT_LEN_LSB];
	assign main_fmt_code_out = main_port_r[`CMP_PORT_FMT_MSB:`CMP_PORT_FMT_LSB];

	assign voice_port_pin_takeover_out = voice_port_r[`CMP_VOICE_TAKEOVER];
	assign voice_slave_out    = voice_port_r[`CMP_VOICE_SLAVE];
	assign voice_adc_en_out   = voice_port_r[`CMP_VOICE_ADC_EN];
	assign voice_bclk_inv_out = voice_port_r[`CMP_VOICE_BCLK_INV];
	assign voice_pcm_mode_b_out = voice_port_r[`CMP_PORT_MODE_BIT] &
	                              (voice_port_r[`CMP_PORT_FMT_MSB:`CMP_PORT_FMT_LSB] == `CMP_FMT_PCM);
	assign voice_frame_inv_out  = frame_inv(voice_port_r[`CMP_PORT_MODE_BIT],
	                                        voice_port_r[`CMP_PORT_FMT_MSB:`CMP_PORT_FMT_LSB]);
	assign voice_len_code_out = voice_port_r[`CMP_PORT_LEN_MSB:`CMP_PORT_LEN_LSB];
	assign voice_fmt_code_out = voice_port_r[`CMP_PORT_FMT_MSB:`CMP_PORT_FMT_LSB];

	assign pwr_en_one_out = pwr_en_one_r;
	assign pwr_en_two_out = pwr_en_two_r;
	assign voice_clk_en_out      = pwr_en_two_r[`CMP_PWR_VOICE_DAC];
	assign voice_port_active_out = pwr_en_two_r[`CMP_PWR_VOICE_DAC] & voice_port_r[`CMP_VOICE_TAKEOVER];
	assign dac_l_clk_en_out      = pwr_en_two_r[`CMP_PWR_DAC_L];
	assign dac_r_clk_en_out      = pwr_en_two_r[`CMP_PWR_DAC_R];
	assign adc_l_clk_en_out      = pwr_en_two_r[`CMP_PWR_ADC_L];
	assign adc_r_clk_en_out      = pwr_en_two_r[`CMP_PWR_ADC_R];

endmodule

// ==== hdl/cmp_regs.vh ====
`ifndef CMP_REGS_VH
`define CMP_REGS_VH

// Register byte addresses
`define CMP_ADDR_SOFT_RESET    8'h00
`define CMP_ADDR_REC_MUTES     8'h14
`define CMP_ADDR_VOICE_VOL     8'h18
`define CMP_ADDR_OUT_MIX       8'h1c
`define CMP_ADDR_RSVD_WORD     8'h20
`define CMP_ADDR_MIC_CTRL      8'h22
`define CMP_ADDR_PWR_DOWN      8'h26
`define CMP_ADDR_MAIN_PORT     8'h34
`define CMP_ADDR_VOICE_PORT    8'h36
`define CMP_ADDR_PWR_EN_ONE    8'h3a
`define CMP_ADDR_PWR_EN_TWO    8'h3c

// Reset values
`define CMP_RST_REC_MUTES      16'h7f7f
`define CMP_RST_VOICE_VOL      16'he800
`define CMP_RST_OUT_MIX        16'h0000
`define CMP_RST_RSVD_WORD      16'h0000
`define CMP_RST_MIC_CTRL       16'h0000
`define CMP_RST_PWR_DOWN       16'hef00
`define CMP_RST_MAIN_PORT      16'h0000
`define CMP_RST_VOICE_PORT     16'h0000
`define CMP_RST_PWR_EN_ONE     16'h0000
`define CMP_RST_PWR_EN_TWO     16'h0000

// Writable bit masks
`define CMP_WM_REC_MUTES       16'h7f7f
`define CMP_WM_VOICE_VOL       16'hff00
`define CMP_WM_OUT_MIX         16'hfbd0
`define CMP_WM_RSVD_WORD       16'hffff
`define CMP_WM_MIC_CTRL        16'h0f33
`define CMP_WM_PWR_DOWN        16'hff00
`define CMP_WM_MAIN_PORT       16'hdfcf
`define CMP_WM_VOICE_PORT      16'hc1cf
`define CMP_WM_PWR_EN_ONE      16'hffff
`define CMP_WM_PWR_EN_TWO      16'hffff

// Field positions
`define CMP_REC_L_MSB          14
`define CMP_REC_L_LSB          8
`define CMP_REC_R_MSB          6
`define CMP_REC_R_LSB          0
`define CMP_VOICE_HP_MUTE      15
`define CMP_VOICE_SPK_MUTE     14
`define CMP_VOICE_MONO_MUTE    13
`define CMP_VOICE_GAIN_MSB     12
`define CMP_VOICE_GAIN_LSB     8
`define CMP_SPK_L_SEL_MSB      15
`define CMP_SPK_L_SEL_LSB      14
`define CMP_AMP_CLASS_D        13
`define CMP_SPK_R_SEL_MSB      12
`define CMP_SPK_R_SEL_LSB      11
`define CMP_HP_L_SEL           9
`define CMP_HP_R_SEL           8
`define CMP_MONO_SEL_MSB       7
`define CMP_MONO_SEL_LSB       6
`define CMP_AB_R_FROM_L        4
`define CMP_MIC1_BOOST_MSB     11
`define CMP_MIC1_BOOST_LSB     10
`define CMP_MIC2_BOOST_MSB     9
`define CMP_MIC2_BOOST_LSB     8
`define CMP_MIC1_BIAS_V        5
`define CMP_MIC2_BIAS_V        4
`define CMP_BIAS_THR_MSB       1
`define CMP_BIAS_THR_LSB       0
`define CMP_PD_SPK             15
`define CMP_PD_LINE_OUT        14
`define CMP_PD_INT_CLK         13
`define CMP_PD_ANALOG_CORE     11
`define CMP_PD_MIXER           10
`define CMP_PD_DAC             9
`define CMP_PD_ADC             8
`define CMP_MAIN_SLAVE         15
`define CMP_MAIN_SEP_ADC_FS    14
`define CMP_MAIN_BCLK_INV      12
`define CMP_MAIN_SD_FROM_DIV   11
`define CMP_MAIN_SD_DIV_MSB    10
`define CMP_MAIN_SD_DIV_LSB    8
`define CMP_MAIN_LIN_FILT      7
`define CMP_PORT_MODE_BIT      6
`define CMP_PORT_LEN_MSB       3
`define CMP_PORT_LEN_LSB       2
`define CMP_PORT_FMT_MSB       1
`define CMP_PORT_FMT_LSB       0
`define CMP_VOICE_TAKEOVER     15
`define CMP_VOICE_SLAVE        14
`define CMP_VOICE_ADC_EN       8
`define CMP_VOICE_BCLK_INV     7
`define CMP_PWR_VOICE_DAC      10
`define CMP_PWR_DAC_L          9
`define CMP_PWR_DAC_R          8
`define CMP_PWR_ADC_L          7
`define CMP_PWR_ADC_R          6

// Format and divider codes
`define CMP_FMT_PCM            2'h3
`define CMP_SD_DIV_MAX         3'h5

`endif

// ==== verif/cmp_analog_model.sv ====
`timescale 1ns/1ps
module cmp_analog_model #(
	parameter SETTLE = 4
) (
	// Clock and reset
	input  wire clk_in,
	input  wire rst_n_in,
	// Power-down gates from the bank
	input  wire vref_pd_in,
	input  wire mixer_pd_in,
	// Readiness levels back to the bank
	output reg  vref_ready_out,
	output reg  mixer_ready_out
);
	reg [3:0] vref_cnt_r;
	reg [3:0] mix_cnt_r;

	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			vref_cnt_r      <= 4'h0;
			mix_cnt_r       <= 4'h0;
			vref_ready_out  <= 1'b0;
			mixer_ready_out <= 1'b0;
		end else begin
			vref_cnt_r      <= vref_pd_in ? 4'h0 : (vref_cnt_r == SETTLE ? vref_cnt_r : vref_cnt_r + 4'h1);
			mix_cnt_r       <= mixer_pd_in ? 4'h0 : (mix_cnt_r == SETTLE ? mix_cnt_r : mix_cnt_r + 4'h1);
			vref_ready_out  <= !vref_pd_in && vref_cnt_r == SETTLE;
			mixer_ready_out <= !mixer_pd_in && mix_cnt_r == SETTLE;
		end
	end
endmodule

// ==== verif/cmp_reg_bank_assertions.sv ====
`timescale 1ns/1ps
module cmp_reg_bank_chk (
	// Clock, reset and register port
	input wire        clk_in,
	input wire        rst_n_in,
	input wire [7:0]  reg_addr_in,
	input wire [15:0] reg_wdata_in,
	input wire        reg_wr_in,
	input wire        reg_rd_in,
	input wire [15:0] reg_rdata_out,
	input wire        reg_rvalid_out,
	// Decoded controls
	input wire [6:0]  rec_left_mute_out,
	input wire [4:0]  voice_gain_code_out,
	input wire        amp_class_select_out,
	input wire        amp_right_from_left_out,
	input wire        adc_pd_out,
	input wire        dac_pd_out,
	input wire        mixer_pd_out,
	input wire        vref_pd_out,
	input wire        int_clk_pd_out,
	input wire        hp_out_pd_out,
	input wire        spk_out_pd_out,
	input wire        main_sep_adc_fs_out,
	input wire        main_frame_inv_out,
	input wire [1:0]  main_fmt_code_out,
	input wire        voice_port_active_out,
	input wire        voice_clk_en_out,
	input wire        voice_port_pin_takeover_out
);
	reg [7:0]  addr_d_r;
	reg [15:0] wdata_d_r;

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);

	always @(posedge clk_in) begin
		addr_d_r  <= reg_addr_in;
		wdata_d_r <= reg_wdata_in;
	end

	rvalid_pulse_a: assert property (reg_rd_in |=> reg_rvalid_out)
		else $error("read not answered next cycle");
	rvalid_cause_a: assert property (reg_rvalid_out |-> $past(reg_rd_in))
		else $error("read valid without a read");
	odd_read_zero_a: assert property (reg_rd_in && reg_addr_in[0] |=> reg_rdata_out == 16'h0000)
		else $error("odd address read not zero");
	rdata_hold_a: assert property (!reg_rvalid_out |-> $stable(reg_rdata_out))
		else $error("read data moved without a read");
	soft_reset_a: assert property (reg_wr_in && reg_addr_in == 8'h00 |=>
		rec_left_mute_out == 7'h7f && voice_gain_code_out == 5'h08 && spk_out_pd_out)
		else $error("soft reset did not restore defaults");
	voice_write_a: assert property (reg_wr_in && reg_addr_in == 8'h18 |=>
		voice_gain_code_out == wdata_d_r[12:8]) else $error("voice gain not written");
	pd_write_a: assert property (reg_wr_in && reg_addr_in == 8'h26 |=>
		spk_out_pd_out == wdata_d_r[15] && vref_pd_out == wdata_d_r[11]) else $error("power-down not written");
	status_ready_a: assert property (reg_rvalid_out && addr_d_r == 8'h26 |->
		reg_rdata_out[1:0] == ~reg_rdata_out[9:8]) else $error("ready status not inverse of request");
	core_gates_a: assert property (vref_pd_out |-> adc_pd_out && dac_pd_out && mixer_pd_out && hp_out_pd_out)
		else $error("core power-down did not gate units");
	clock_gates_a: assert property (int_clk_pd_out |-> adc_pd_out && dac_pd_out)
		else $error("clock power-down did not gate converters");
	class_d_a: assert property (amp_class_select_out |-> !amp_right_from_left_out)
		else $error("right from left outside class AB");
	frame_inv_a: assert property (main_frame_inv_out |-> !main_sep_adc_fs_out && main_fmt_code_out != 2'h3)
		else $error("frame inversion not allowed here");
	voice_gate_a: assert property (voice_port_active_out |-> voice_clk_en_out && voice_port_pin_takeover_out)
		else $error("voice port active without clock");

	cover property (reg_wr_in && reg_addr_in == 8'h00);
	cover property (reg_rvalid_out && addr_d_r == 8'h26);
	cover property (amp_right_from_left_out);
	cover property (main_frame_inv_out);
endmodule

bind cmp_reg_bank cmp_reg_bank_chk cmp_reg_bank_chk_i (.clk_in, .rst_n_in, .reg_addr_in, .reg_wdata_in,
	.reg_wr_in, .reg_rd_in, .reg_rdata_out, .reg_rvalid_out, .rec_left_mute_out, .voice_gain_code_out,
	.amp_class_select_out, .amp_right_from_left_out, .adc_pd_out, .dac_pd_out, .mixer_pd_out, .vref_pd_out,
	.int_clk_pd_out, .hp_out_pd_out, .spk_out_pd_out, .main_sep_adc_fs_out, .main_frame_inv_out,
	.main_fmt_code_out, .voice_port_active_out, .voice_clk_en_out, .voice_port_pin_takeover_out);

// ==== verif/cmp_reg_bank_bench.sv ====
`timescale 1ns/1ps
`include "cmp_regs.vh"
module cmp_reg_bank_bench;
	reg         clk_in = 1'b0;
	reg         rst_n_in = 1'b0;
	reg  [7:0]  reg_addr_in = 8'h00;
	reg  [15:0] reg_wdata_in = 16'h0000;
	reg         reg_wr_in = 1'b0;
	reg         reg_rd_in = 1'b0;
	wire        vref_ready_in, mixer_ready_in, reg_rvalid_out, voice_hp_mute_out, voice_spk_mute_out;
	wire        voice_mono_mute_out, amp_class_select_out, amp_right_from_left_out, hp_left_from_mixer_out;
	wire        hp_right_from_mixer_out, first_mic_supply_low_out, second_mic_supply_low_out, adc_pd_out;
	wire        dac_pd_out, mixer_pd_out, vref_pd_out, int_clk_pd_out, hp_out_pd_out, mono_out_pd_out;
	wire        spk_out_pd_out, main_slave_out, main_sep_adc_fs_out, main_bclk_inv_out, main_sd_from_div_out;
	wire        main_sd_div_valid_out, main_lin_filter_out, main_pcm_mode_b_out, main_frame_inv_out;
	wire        voice_port_pin_takeover_out, voice_slave_out, voice_adc_en_out, voice_bclk_inv_out;
	wire        voice_pcm_mode_b_out, voice_frame_inv_out, voice_clk_en_out, voice_port_active_out;
	wire        dac_l_clk_en_out, dac_r_clk_en_out, adc_l_clk_en_out, adc_r_clk_en_out;
	wire [1:0]  speaker_left_gain_stage_sel_out, speaker_right_gain_stage_sel_out, mono_in_sel_out;
	wire [1:0]  first_mic_preamp_gain_out, second_mic_preamp_gain_out, bias_threshold_level_out;
	wire [1:0]  main_len_code_out, main_fmt_code_out, voice_len_code_out, voice_fmt_code_out;
	wire [2:0]  main_sd_div_log2_out;
	wire [4:0]  voice_gain_code_out;
	wire [6:0]  rec_left_mute_out, rec_right_mute_out;
	wire [15:0] reg_rdata_out, pwr_en_one_out, pwr_en_two_out;
	reg  [15:0] mdl [0:31];
	reg  [31:0] seed;
	integer     errors = 0;
	integer     cmp_count = 0;
	integer     cyc = 0;
	integer     n;

	cmp_reg_bank cmp_reg_bank_i (.*);
	cmp_analog_model cmp_analog_model_i (.clk_in, .rst_n_in, .vref_pd_in(vref_pd_out), .mixer_pd_in(mixer_pd_out),
		.vref_ready_out(vref_ready_in), .mixer_ready_out(mixer_ready_in));

	always #5 clk_in = ~clk_in;

	// Write mask in the upper half, reset value in the lower
	function [31:0] info(input [7:0] a);
		case (a)
			`CMP_ADDR_REC_MUTES:  info = {`CMP_WM_REC_MUTES, `CMP_RST_REC_MUTES};
			`CMP_ADDR_VOICE_VOL:  info = {`CMP_WM_VOICE_VOL, `CMP_RST_VOICE_VOL};
			`CMP_ADDR_OUT_MIX:    info = {`CMP_WM_OUT_MIX, `CMP_RST_OUT_MIX};
			`CMP_ADDR_RSVD_WORD:  info = {`CMP_WM_RSVD_WORD, `CMP_RST_RSVD_WORD};
			`CMP_ADDR_MIC_CTRL:   info = {`CMP_WM_MIC_CTRL, `CMP_RST_MIC_CTRL};
			`CMP_ADDR_PWR_DOWN:   info = {`CMP_WM_PWR_DOWN, `CMP_RST_PWR_DOWN};
			`CMP_ADDR_MAIN_PORT:  info = {`CMP_WM_MAIN_PORT, `CMP_RST_MAIN_PORT};
			`CMP_ADDR_VOICE_PORT: info = {`CMP_WM_VOICE_PORT, `CMP_RST_VOICE_PORT};
			`CMP_ADDR_PWR_EN_ONE: info = {`CMP_WM_PWR_EN_ONE, `CMP_RST_PWR_EN_ONE};
			`CMP_ADDR_PWR_EN_TWO: info = {`CMP_WM_PWR_EN_TWO, `CMP_RST_PWR_EN_TWO};
			default:              info = 32'h0;
		endcase
	endfunction

	function [15:0] exp_rd(input [7:0] a);
		reg [31:0] f;
		begin
			f = info(a);
			exp_rd = (f[31:16] != 16'h0) ? mdl[a[5:1]] : 16'h0000;
			if (a == `CMP_ADDR_PWR_DOWN)
				exp_rd[3:0] = {vref_ready_in, mixer_ready_in, ~exp_rd[9:8]};
		end
	endfunction

	task mdl_reset;
		integer i;
		reg [31:0] f;
		begin
			for (i = 0; i < 32; i = i + 1) begin
				f = info({i[6:0], 1'b0});
				mdl[i] = f[15:0];
			end
		end
	endtask

	task chk(input [63:0] seen, input [63:0] exp);
		begin
			cmp_count = cmp_count + 1;
			if (seen !== exp) begin
				errors = errors + 1;
				$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
			end
		end
	endtask

	task chk_dec;
		reg [15:0] q, g, o, c, p, m, v, e, w;
		begin
			q = mdl[`CMP_ADDR_REC_MUTES >> 1];
			g = mdl[`CMP_ADDR_VOICE_VOL >> 1];
			o = mdl[`CMP_ADDR_OUT_MIX >> 1];
			c = mdl[`CMP_ADDR_MIC_CTRL >> 1];
			p = mdl[`CMP_ADDR_PWR_DOWN >> 1];
			m = mdl[`CMP_ADDR_MAIN_PORT >> 1];
			v = mdl[`CMP_ADDR_VOICE_PORT >> 1];
			e = mdl[`CMP_ADDR_PWR_EN_ONE >> 1];
			w = mdl[`CMP_ADDR_PWR_EN_TWO >> 1];
			chk({rec_left_mute_out, rec_right_mute_out}, {q[14:8], q[6:0]});
			chk({voice_hp_mute_out, voice_spk_mute_out, voice_mono_mute_out, voice_gain_code_out}, g[15:8]);
			chk({speaker_left_gain_stage_sel_out, amp_class_select_out, speaker_right_gain_stage_sel_out,
				hp_left_from_mixer_out, hp_right_from_mixer_out, mono_in_sel_out, amp_right_from_left_out},
				{o[15:11], o[9:6], ~o[13] & o[4]});
			chk({first_mic_preamp_gain_out, second_mic_preamp_gain_out, first_mic_supply_low_out,
				second_mic_supply_low_out, bias_threshold_level_out},
				{c[11:8], c[5:4], c[1] ? 2'h2 : {1'b0, c[0]}});
			chk({adc_pd_out, dac_pd_out, mixer_pd_out, vref_pd_out, int_clk_pd_out, hp_out_pd_out, mono_out_pd_out,
				spk_out_pd_out}, {p[8] | p[11] | p[13], p[9] | p[11] | p[13], p[10] | p[11], p[11], p[13],
				p[10] | p[11] | p[14], p[14], p[15]});
			chk({main_slave_out, main_sep_adc_fs_out, main_bclk_inv_out, main_sd_from_div_out, main_sd_div_valid_out,
				main_sd_div_log2_out, main_lin_filter_out, main_len_code_out, main_fmt_code_out},
				{m[15:14], m[12:11], m[10:8] <= 3'h5, m[10:8] + 3'h1, m[7], m[3:0]});
			chk({main_pcm_mode_b_out, main_frame_inv_out, voice_pcm_mode_b_out, voice_frame_inv_out},
				{m[6] & (&m[1:0]), m[6] & ~(&m[1:0]) & ~m[14], v[6] & (&v[1:0]), v[6] & ~(&v[1:0])});
			chk({voice_port_pin_takeover_out, voice_slave_out, voice_adc_en_out, voice_bclk_inv_out,
				voice_len_code_out, voice_fmt_code_out}, {v[15:14], v[8:7], v[3:0]});
			chk({pwr_en_one_out, pwr_en_two_out}, {e, w});
			chk({voice_clk_en_out, voice_port_active_out, dac_l_clk_en_out, dac_r_clk_en_out, adc_l_clk_en_out,
				adc_r_clk_en_out}, {w[10], w[10] & v[15], w[9:6]});
		end
	endtask

	// One access; a read returns the value from before a same-cycle write
	task acc(input [7:0] a, input [15:0] d, input w, input r);
		reg [15:0] ex;
		reg [31:0] f;
		begin
			@(posedge clk_in);
			reg_addr_in <= a;
			reg_wdata_in <= d;
			reg_wr_in <= w;
			reg_rd_in <= r;
			@(posedge clk_in);
			ex = exp_rd(a);
			reg_wr_in <= 1'b0;
			reg_rd_in <= 1'b0;
			#1;
			chk(reg_rvalid_out, r);
			if (r)
				chk(reg_rdata_out, ex);
			f = info(a);
			if (w && a == `CMP_ADDR_SOFT_RESET)
				mdl_reset;
			else if (w)
				mdl[a[5:1]] = (d & f[31:16]) | (mdl[a[5:1]] & ~f[31:16]);
			chk_dec;
		end
	endtask

	task sweep;
		integer a;
		begin
			for (a = 0; a < 64; a = a + 1)
				acc(a[7:0], 16'h0000, 1'b0, 1'b1);
		end
	endtask

	task final_report;
		begin
			$display("Comparisons %0d, mismatches %0d", cmp_count, errors);
			if (errors == 0 && cmp_count > 0)
				$display("Test passed");
			else
				$display("Test failed");
			$finish;
		end
	endtask

	always @(posedge clk_in) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			errors = errors + 1;
			final_report;
		end
	end

	initial begin
		seed = $urandom(23);
		mdl_reset;
		repeat (2) @(posedge clk_in);
		rst_n_in <= 1'b1;
		sweep;
		for (n = 1; n < 64; n = n + 1)
			acc(n[7:0], 16'($urandom) & ((n == 52) ? 16'hfffd : 16'hffff), 1'b1, 1'b1); // host rule
		sweep;
		for (n = 0; n < 8; n = n + 1)
			acc(8'h26, 16'h0100 << n, 1'b1, 1'b1);
		for (n = 0; n < 16; n = n + 1) begin
			acc(8'h34, {1'b0, n[3], 3'h0, n[2:0], 1'b0, n[2], 4'h0, n[1:0]}, 1'b1, 1'b0);
			acc(8'h36, {1'b1, n[3], 5'h00, n[0], n[1], n[2], 4'h0, n[1:0]}, 1'b1, 1'b0);
		end
		acc(8'h1c, 16'h0010, 1'b1, 1'b0);
		acc(8'h1c, 16'h2010, 1'b1, 1'b0);
		acc(8'h3c, 16'hffff, 1'b1, 1'b0);
		acc(8'h00, 16'hffff, 1'b1, 1'b0);
		sweep;
		acc(8'h3a, 16'h5a5a, 1'b1, 1'b0);
		@(posedge clk_in);
		rst_n_in <= 1'b0;
		repeat (2) @(posedge clk_in);
		rst_n_in <= 1'b1;
		mdl_reset;
		sweep;
		final_report;
	end
endmodule
